// ===== design/odac_top.sv
`timescale 1ns/1ns
module odac_top #(
  parameter int SAMPLE_W = 9,
  parameter int INIT_CYCLES = odac_pkg::INIT_CYCLES
) (
  input wire logic i_ref_clk, // sampling clock, 100 MHz
  input wire logic i_rst_b, // async reset, active low
  input wire logic [SAMPLE_W-1:0] i_sample_a, // channel a sample
  input wire logic [SAMPLE_W-1:0] i_sample_b, // channel b sample
  input wire logic [SAMPLE_W-1:0] i_sample_c, // channel c sample
  input wire logic [SAMPLE_W-1:0] i_sample_d, // channel d sample
  input wire logic i_spi_cs_b, // serial chip select, active low
  input wire logic i_spi_sclk, // serial clock, sampled
  input wire logic i_spi_sdi, // serial data in
  output logic o_spi_sdo, // serial data out
  output logic o_overrange_out_a, // channel a over-range
  output logic o_overrange_out_b, // channel b over-range
  output logic o_overrange_out_c, // channel c over-range
  output logic o_overrange_out_d, // channel d over-range
  output logic [7:0] o_power_profile_code_two, // current profile code
  output logic o_init_done // initialization complete
);

  localparam int NCH = 4;
  localparam int INIT_W = $clog2(INIT_CYCLES + 1);

  logic [7:0] threshold_q;
  odac_pkg::odac_overrange_config_t cfg_q;
  logic [7:0] profile_q;
  logic [INIT_W-1:0] init_cnt_q;
  logic sclk_q;
  logic [4:0] bit_cnt_q;
  logic [odac_pkg::SPI_FRAME_BITS-1:0] rx_q;
  logic [7:0] tx_q;
  logic [NCH-1:0] ovr;
  logic [NCH*SAMPLE_W-1:0] samples;

  wire sclk_rise = !i_spi_cs_b & i_spi_sclk & !sclk_q;
  wire sclk_fall = !i_spi_cs_b & !i_spi_sclk & sclk_q;
  wire [odac_pkg::SPI_FRAME_BITS-1:0] rx_next = {rx_q[odac_pkg::SPI_FRAME_BITS-2:0], i_spi_sdi};
  odac_pkg::odac_spi_frame_t frame;
  assign frame = rx_next;
  wire hdr_done = sclk_rise & (bit_cnt_q == odac_pkg::SPI_LAST_HDR_BIT);
  wire wr_commit = sclk_rise & (bit_cnt_q == odac_pkg::SPI_LAST_BIT) & !frame.rd;
  wire [odac_pkg::SPI_ADDR_W-1:0] hdr_addr = rx_next[odac_pkg::SPI_ADDR_W-1:0];
  wire wr_level = wr_commit & (frame.addr == odac_pkg::OFS_OVERRANGE_LEVEL);
  wire wr_cfg = wr_commit & (frame.addr == odac_pkg::OFS_OVERRANGE_CONTROL);
  wire code_ok = (frame.data == odac_pkg::PROFILE_LOW_POWER) || (frame.data == odac_pkg::PROFILE_HIGH_PERF);
  wire wr_profile = wr_commit & (frame.addr == odac_pkg::OFS_POWER_PROFILE_TWO) & code_ok;
  wire init_done = (init_cnt_q == INIT_W'(INIT_CYCLES));

  // read address decode, taken from the header as it completes
  wire rd_sel_level = (hdr_addr == odac_pkg::OFS_OVERRANGE_LEVEL);
  wire rd_sel_cfg = (hdr_addr == odac_pkg::OFS_OVERRANGE_CONTROL);
  wire rd_sel_state = (hdr_addr == odac_pkg::OFS_STARTUP_STATE);
  wire rd_sel_profile = (hdr_addr == odac_pkg::OFS_POWER_PROFILE_TWO);

  // read mux; unmapped addresses return zero
  logic [7:0] rdata;
  assign rdata = rd_sel_level ? threshold_q :
                 rd_sel_cfg ? cfg_q :
                 rd_sel_state ? {7'h00, init_done} :
                 rd_sel_profile ? profile_q : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      init_cnt_q <= '0;
    end else if (!init_done) begin
      init_cnt_q <= init_cnt_q + 1'b1;
    end
  end

  // serial shifter: mode 0, msb first, sdo changes on falling edges
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      o_spi_sdo <= 1'b0;
    end else begin
      sclk_q <= i_spi_sclk;
      if (i_spi_cs_b) begin
        bit_cnt_q <= '0;
      end else if (sclk_rise) begin
        rx_q <= rx_next;
        bit_cnt_q <= (bit_cnt_q == odac_pkg::SPI_LAST_BIT) ? '0 : bit_cnt_q + 1'b1;
      end
      if (hdr_done) begin
        tx_q <= rdata;
      end else if (sclk_fall && bit_cnt_q > odac_pkg::SPI_LAST_HDR_BIT) begin
        o_spi_sdo <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      threshold_q <= odac_pkg::RST_OVERRANGE_THRESHOLD;
      cfg_q <= odac_pkg::RST_OVERRANGE_CONTROL;
      profile_q <= odac_pkg::RST_POWER_PROFILE_TWO;
    end else begin
      if (wr_level) begin
        threshold_q <= frame.data;
      end
      if (wr_cfg) begin
        cfg_q <= frame.data;
      end
      if (wr_profile) begin
        profile_q <= frame.data;
      end
    end
  end

  assign samples = {i_sample_d, i_sample_c, i_sample_b, i_sample_a};

  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      odac_stretch #(
        .SAMPLE_W(SAMPLE_W)
      ) u_stretch (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_sample(samples[ch*SAMPLE_W +: SAMPLE_W]),
        .i_threshold(threshold_q),
        .i_enable(cfg_q.enable),
        .i_hold_exp(cfg_q.hold_exp),
        .o_out(ovr[ch])
      );
      chk_chan_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !cfg_q.enable |=> !ovr[ch])
        else $error("channel over-range output high while disabled");
    end
  endgenerate

  assign o_overrange_out_a = ovr[0];
  assign o_overrange_out_b = ovr[1];
  assign o_overrange_out_c = ovr[2];
  assign o_overrange_out_d = ovr[3];
  assign o_power_profile_code_two = profile_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_init_done <= 1'b0;
    end else begin
      o_init_done <= init_done;
    end
  end

  chk_profile_legal: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (profile_q == odac_pkg::PROFILE_LOW_POWER) || (profile_q == odac_pkg::PROFILE_HIGH_PERF))
    else $error("power profile holds a reserved code");
  chk_profile_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (wr_commit && frame.addr == odac_pkg::OFS_POWER_PROFILE_TWO && !code_ok) |=> $stable(profile_q))
    else $error("reserved profile code was taken");
  chk_init_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (init_cnt_q < INIT_W'(INIT_CYCLES)) |=> !o_init_done) else $error("init done reported early");
  chk_level_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_level |=> (threshold_q == $past(frame.data))) else $error("threshold write lost");
  chk_level_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !wr_level |=> $stable(threshold_q))
    else $error("threshold changed without a write");

  // configuration and profile registers change only on a committed write
  chk_cfg_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_cfg |=> (cfg_q == $past(frame.data)))
    else $error("config write lost");
  chk_cfg_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !wr_cfg |=> $stable(cfg_q))
    else $error("config changed without a write");
  chk_profile_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_profile |=> (profile_q == $past(frame.data)))
    else $error("legal profile code not taken");
  chk_profile_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !wr_profile |=> $stable(profile_q))
    else $error("profile changed without a legal write");

  // startup status: counts up, then reports done and stays done
  chk_init_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !init_done |=> (init_cnt_q == $past(init_cnt_q) + 1'b1))
    else $error("init counter did not advance");
  chk_init_rise: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    init_done |=> o_init_done)
    else $error("init done not reported");
  chk_init_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_init_done |=> o_init_done)
    else $error("init done dropped");

  // read path: byte loaded at header end, shifted out on falling edges
  chk_read_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    hdr_done |=> (tx_q == $past(rdata)))
    else $error("read byte not loaded");
  chk_status_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (hdr_done && rd_sel_state) |=> (tx_q == {7'h00, $past(init_done)}))
    else $error("status byte wrong");
  chk_sdo_shift: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (sclk_fall && (bit_cnt_q > odac_pkg::SPI_LAST_HDR_BIT)) |=> (o_spi_sdo == $past(tx_q[7])))
    else $error("read bit not shifted out");
  chk_sdo_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !sclk_fall |=> $stable(o_spi_sdo))
    else $error("read bit changed between falling edges");
  cov_low_power: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_profile && frame.data == odac_pkg::PROFILE_LOW_POWER);
  cov_init: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) $rose(o_init_done));
  cov_all_over: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) &ovr);
  cov_status_read: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    hdr_done && rd_sel_state && init_done);

endmodule : odac_top

// ===== design/odac_pkg.sv
package odac_pkg;

  // register offsets on the serial port
  localparam logic [14:0] OFS_OVERRANGE_LEVEL = 15'h0211;
  localparam logic [14:0] OFS_OVERRANGE_CONTROL = 15'h0213;
  localparam logic [14:0] OFS_STARTUP_STATE = 15'h0270;
  localparam logic [14:0] OFS_POWER_PROFILE_TWO = 15'h029a;

  // reset values
  localparam logic [7:0] RST_OVERRANGE_THRESHOLD = 8'hf2;
  localparam logic [7:0] RST_OVERRANGE_CONTROL = 8'h07;
  localparam logic [7:0] RST_POWER_PROFILE_TWO = 8'h0f;

  // power profile codes
  localparam logic [7:0] PROFILE_LOW_POWER = 8'h06;
  localparam logic [7:0] PROFILE_HIGH_PERF = 8'h0f;

  // overrange_config field positions
  localparam int CFG_ENABLE_BIT = 3;
  localparam int CFG_EXP_LSB = 0;
  localparam int CFG_EXP_W = 3;

  // minimum pulse is HOLD_BASE << exponent sampling cycles
  localparam int HOLD_BASE = 4;
  localparam int HOLD_CNT_W = 10;

  // serial frame: 1 direction bit, 15 address bits, 8 data bits
  localparam int SPI_ADDR_W = 15;
  localparam int SPI_FRAME_BITS = 24;
  localparam logic [4:0] SPI_LAST_HDR_BIT = 5'd15;
  localparam logic [4:0] SPI_LAST_BIT = 5'd23;

  // cycles of internal initialization sequencing after reset
  localparam int INIT_CYCLES = 1024;

  typedef struct packed {
    logic rd;
    logic [SPI_ADDR_W-1:0] addr;
    logic [7:0] data;
  } odac_spi_frame_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic enable;
    logic [CFG_EXP_W-1:0] hold_exp;
  } odac_overrange_config_t;

endpackage : odac_pkg

// ===== design/odac_stretch.sv
`timescale 1ns/1ns
module odac_stretch #(
  parameter int SAMPLE_W = 9
) (
  input wire logic i_ref_clk, // sampling clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic [SAMPLE_W-1:0] i_sample, // two's complement sample
  input wire logic [7:0] i_threshold, // level, 256 = full scale
  input wire logic i_enable, // over-range output enable
  input wire logic [odac_pkg::CFG_EXP_W-1:0] i_hold_exp, // hold exponent
  output logic o_out // stretched over-range flag
);

  logic [SAMPLE_W-1:0] mag;
  logic hit;
  logic [odac_pkg::HOLD_CNT_W-1:0] len_m1;
  logic [odac_pkg::HOLD_CNT_W-1:0] cnt_q;
  logic [odac_pkg::HOLD_CNT_W-1:0] cnt_d;
  logic out_d;

  // magnitude of -full scale is exactly 256
  assign mag = i_sample[SAMPLE_W-1] ? SAMPLE_W'(~i_sample + 1'b1) : i_sample;
  assign hit = (mag >= SAMPLE_W'(i_threshold));
  assign len_m1 = odac_pkg::HOLD_CNT_W'((odac_pkg::HOLD_BASE << i_hold_exp) - 1);
  assign out_d = i_enable & (hit | (o_out & (cnt_q != '0)));
  assign cnt_d = !i_enable ? '0 : hit ? len_m1 : (cnt_q != '0) ? cnt_q - 1'b1 : '0;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      o_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_out <= out_d;
    end
  end

  chk_gate_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_enable |=> !o_out) else $error("over-range output high while disabled");
  chk_hit_sets: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_enable && hit) |=> o_out) else $error("threshold reached but output low");
  chk_no_false: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!hit && (cnt_q == '0)) |=> !o_out) else $error("output high without cause");
  chk_hold_min: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_enable && i_hold_exp == 3'd0 && hit) ##1 i_enable[*3] |=>
    ($past(o_out, 3) && $past(o_out, 2) && $past(o_out) && o_out))
    else $error("minimum pulse of 4 cycles cut short");
  chk_hold_restart: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_enable && hit && o_out) |=> (cnt_q == $past(len_m1))) else $error("hold count not restarted");
  cov_restart: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_out && cnt_q != '0 && hit && i_enable);

endmodule : odac_stretch

// ===== tb/odac_host_model.sv
`timescale 1ns/1ns
module odac_host_model (
  input wire logic i_ref_clk, // sampling clock
  input wire logic i_spi_sdo, // read data from the device
  output logic o_spi_cs_b, // select, active low
  output logic o_spi_sclk, // serial clock
  output logic o_spi_sdi, // serial data to the device
  output logic o_rd_done, // one-clock read strobe
  output logic [7:0] o_rd_data // byte read back
);
  initial begin
    o_spi_cs_b = 1'b1;
    o_spi_sclk = 1'b0;
    o_spi_sdi = 1'b0;
    o_rd_done = 1'b0;
    o_rd_data = 8'h00;
  end
  // four reference clocks per serial phase, above the two-clock minimum
  task automatic half();
    repeat (4) @(negedge i_ref_clk);
  endtask : half
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd);
    odac_pkg::odac_spi_frame_t f;
    f = '{rd: rd, addr: addr, data: wd};
    @(negedge i_ref_clk);
    o_spi_cs_b = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_spi_sdi = f[i];
      half();
      if (i < 8) o_rd_data[i] = i_spi_sdo;
      o_spi_sclk = 1'b1;
      half();
      o_spi_sclk = 1'b0;
    end
    half();
    o_spi_cs_b = 1'b1;
    o_spi_sdi = ~o_spi_sdi; // a released line does not keep its last bit
    o_rd_done = rd;
    @(negedge i_ref_clk);
    o_rd_done = 1'b0;
  endtask : xfer
  task automatic config_ovr(input logic en, input logic [2:0] hexp);
    xfer(1'b0, odac_pkg::OFS_OVERRANGE_CONTROL, {4'h0, en, hexp});
  endtask : config_ovr
  // link and calibration enables stay clear; the other profile registers
  // and the follow-up calibration live outside this block
  task automatic set_profile(input logic [7:0] code);
    xfer(1'b0, odac_pkg::OFS_POWER_PROFILE_TWO, code);
  endtask : set_profile
endmodule : odac_host_model

// ===== tb/odac_top_tb.sv
`timescale 1ns/1ns
module odac_top_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic signed [8:0] smp [4] = '{default: '0};
  logic [3:0] hit_m = '0;
  logic [8:0] hit_v = '0;
  logic cs_b, sclk, sdi, sdo, rd_done, init_done, ovr_v;
  logic [7:0] rd_data, prof;
  logic [15:0] ovr_res;
  logic [15:0] exp_q [$];
  wire [3:0] ovr;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'hb479_0bb6;
  logic [7:0] codes [4] = '{8'h06, 8'h55, 8'h0f, 8'h00};
  logic [7:0] kept [4] = '{8'h06, 8'h06, 8'h0f, 8'h0f};
  int exps [3] = '{0, 2, 7};
  always #5 i_ref_clk = ~i_ref_clk;
  // random levels stay below the programmed threshold of 128
  always @(negedge i_ref_clk)
    for (int c = 0; c < 4; c++) smp[c] <= hit_m[c] ? hit_v : 9'($signed($random(seed)) % 127);
  odac_top #(.SAMPLE_W(9), .INIT_CYCLES(8)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_sample_a(smp[0]), .i_sample_b(smp[1]), .i_sample_c(smp[2]), .i_sample_d(smp[3]),
    .i_spi_cs_b(cs_b), .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
    .o_overrange_out_a(ovr[0]), .o_overrange_out_b(ovr[1]), .o_overrange_out_c(ovr[2]),
    .o_overrange_out_d(ovr[3]), .o_power_profile_code_two(prof), .o_init_done(init_done));
  odac_host_model host_u (.i_ref_clk(i_ref_clk), .i_spi_sdo(sdo), .o_spi_cs_b(cs_b),
    .o_spi_sclk(sclk), .o_spi_sdi(sdi), .o_rd_done(rd_done), .o_rd_data(rd_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  always @(posedge i_ref_clk)
    if (rd_done === 1'b1 || ovr_v === 1'b1) begin
      if (exp_q.size() == 0) miscompares++;
      else check(ovr_v ? ovr_res : {8'h00, rd_data}, exp_q.pop_front());
    end
  task automatic rd_exp(input logic [14:0] a, input logic [7:0] want);
    exp_q.push_back({8'h00, want});
    host_u.xfer(1'b1, a, 8'h00);
  endtask : rd_exp
  task automatic put_res(input logic [15:0] v, input logic [15:0] want);
    exp_q.push_back(want);
    @(negedge i_ref_clk);
    ovr_res = v;
    ovr_v = 1'b1;
    @(negedge i_ref_clk);
    ovr_v = 1'b0;
  endtask : put_res
  // one or two hits spaced gap cycles apart, then the pulse length is measured
  task automatic pulse(input logic [3:0] m, input logic [8:0] v, input int gap, input int want);
    int n;
    logic [3:0] first;
    n = 0;
    first = '0;
    fork
      begin
        @(posedge i_ref_clk) {hit_m, hit_v} <= {m, v};
        @(posedge i_ref_clk) hit_m <= '0;
        if (gap > 0) begin
          repeat (gap - 1) @(posedge i_ref_clk);
          hit_m <= m;
          @(posedge i_ref_clk) hit_m <= '0;
        end
      end
      begin
        for (int i = 0; i < 10 && (ovr & m) == 0; i++) @(negedge i_ref_clk);
        first = ovr;
        while ((ovr & m) != 0 && n < 3000) begin
          n++;
          @(negedge i_ref_clk);
        end
      end
    join
    put_res({12'h000, first}, {12'h000, want > 0 ? m : 4'h0});
    put_res(16'(n), 16'(want));
  endtask : pulse
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    ovr_v = 1'b0;
    ovr_res = '0;
    repeat (2) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    @(negedge i_ref_clk);
    check({15'h0000, init_done}, 16'h0000);
    check({8'h00, prof}, 16'h000f);
    for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(negedge i_ref_clk);
    if (init_done !== 1'b1) begin
      miscompares++;
    end else begin
      rd_exp(odac_pkg::OFS_OVERRANGE_LEVEL, 8'hf2);
      rd_exp(odac_pkg::OFS_OVERRANGE_CONTROL, 8'h07);
      rd_exp(odac_pkg::OFS_STARTUP_STATE, 8'h01);
      rd_exp(odac_pkg::OFS_POWER_PROFILE_TWO, 8'h0f);
      rd_exp(15'h03ff, 8'h00);
      for (int k = 0; k < 4; k++) begin
        host_u.set_profile(codes[k]);
        rd_exp(odac_pkg::OFS_POWER_PROFILE_TWO, kept[k]);
        check({8'h00, prof}, {8'h00, kept[k]});
      end
      host_u.xfer(1'b0, odac_pkg::OFS_OVERRANGE_LEVEL, 8'h80);
      rd_exp(odac_pkg::OFS_OVERRANGE_LEVEL, 8'h80);
      for (int k = 0; k < 3; k++) begin
        host_u.config_ovr(1'b1, 3'(exps[k]));
        pulse(4'(1 << k), k[0] ? 9'h180 : 9'h080, 0, 4 << exps[k]);
      end
      host_u.config_ovr(1'b1, 3'h0);
      pulse(4'h2, 9'h07f, 0, 0);
      pulse(4'hf, 9'h100, 3, 7);
      host_u.config_ovr(1'b0, 3'h0);
      pulse(4'hf, 9'h100, 0, 0);
    end
    repeat (2) @(negedge i_ref_clk);
    if (exp_q.size() != 0) miscompares++;
    print_verdict();
  end
endmodule : odac_top_tb
